/* File: src/lcd_driver_host_bus_port.sv */
`timescale 1ns/10ps
`include "host_port_defs.svh"
// Overview of operation
// [RULE1] Selected only when select_low_in low, select_high_in high
// [RULE2] Data bus high impedance when not selected
// [RULE3] Parallel data bus is eight bits
// [RULE4] data_cmd_sel high data, low command
// [RULE5] Strap high enable style, low split
// [RULE6] Split style: drive bus while read low
// [RULE7] Split style: capture on write rising edge
// [RULE8] Enable style: high enable pulse does transfer
// [RULE9] Enable style: direction high read, low write
// [RULE10] Level-sensitive reset restores initial settings
// [RULE11] Serial: bit 7 data, bit 6 clock
// [RULE12] Host ties bits 0-5 fixed in serial
// [RULE13] Link strap high parallel, low serial
// [RULE14] Serial eight bits MSB first, dc with last
// [RULE15] Strobes ignored while not selected
module lcd_driver_host_bus_port #(
    parameter int DW = `HP_DATA_W
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset,
    // Host pins
    input  wire logic          init_in_n,
    input  wire logic          select_low_in,
    input  wire logic          select_high_in,
    input  wire logic          data_cmd_sel,
    input  wire logic          rd_strobe_in,
    input  wire logic          wr_strobe_in,
    input  wire logic [DW-1:0] data_in,
    output logic      [DW-1:0] data_out,
    output logic      [DW-1:0] data_oe,
    // Straps
    input  wire logic          bus_style_strap,
    input  wire logic          link_sel_strap,
    // Core side
    output logic               wr_vld,
    output logic      [DW-1:0] wr_byte,
    output logic               wr_is_data,
    output logic               rd_req,
    output logic               rd_is_data,
    input  wire logic [DW-1:0] rd_byte,
    output logic               init_active
);
    localparam int NS = 7;

    logic [NS-1:0] pins_s;
    logic [DW-1:0] data_s;
    logic          link_s;
    logic          init_ff;
    logic          rd_prev_ff;
    logic          wr_prev_ff;
    logic          scl_prev_ff;
    logic          wv_ff;
    logic [DW-1:0] wb_ff;
    logic          wd_ff;
    logic          rq_ff;
    logic          rqd_ff;
    logic [DW-1:0] dout_ff;
    logic          oe_ff;
    logic          ser_vld;
    logic [DW-1:0] ser_byte;
    logic          ser_dc;

    pin_sync #(.W(NS)) u_ctl_sync (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .pin_in       ({init_in_n, select_low_in, select_high_in, data_cmd_sel,
                        rd_strobe_in, wr_strobe_in, bus_style_strap}),
        .pin_sync_out (pins_s)
    );

    pin_sync #(.W(DW + 1)) u_dat_sync (
        .clk_sys      (clk_sys),
        .reset        (reset),
        .pin_in       ({link_sel_strap, data_in}),
        .pin_sync_out ({link_s, data_s})
    );

    wire init_n_s = pins_s[6];
    wire sel_l_s  = pins_s[5];
    wire sel_h_s  = pins_s[4];
    wire dc_s     = pins_s[3];
    wire rd_s     = pins_s[2];
    wire wr_s     = pins_s[1];
    wire style_s  = pins_s[0];

    wire selected = !sel_l_s && sel_h_s; // RULE1
    wire parallel = link_s == host_port_pkg::LINK_PARALLEL; // RULE13
    wire en_style = style_s == host_port_pkg::STYLE_ENABLE; // RULE5
    wire live     = selected && init_ff; // RULE15

    // Split style
    wire split_rd = !en_style && !rd_s; // RULE6
    wire split_wr = !en_style && wr_s && !wr_prev_ff; // RULE7
    // Enable style: rd pin is enable, wr pin is direction
    wire en_high  = en_style && rd_s; // RULE8
    wire en_rise  = en_style && rd_s && !rd_prev_ff;
    wire en_fall  = en_style && !rd_s && rd_prev_ff;
    wire en_rd    = en_high && wr_s; // RULE9
    wire en_wr    = en_fall && !wr_s; // RULE9

    wire par_read   = live && parallel && (split_rd || en_rd);
    wire par_write  = live && parallel && (split_wr || en_wr);
    wire read_start = live && parallel && ((!en_style && !rd_s && rd_prev_ff)
                      || (en_rise && wr_s));

    wire scl      = data_s[`HP_SCL_BIT]; // RULE11
    wire si       = data_s[`HP_SI_BIT];  // RULE11
    wire scl_rise = live && !parallel && scl && !scl_prev_ff; // RULE14

    serial_shifter #(.BITS(DW)) u_shift (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .clear    (!live || parallel),
        .shift_en (scl_rise),
        .bit_in   (si),
        .dc_in    (dc_s),
        .byte_vld (ser_vld),
        .byte_out (ser_byte),
        .byte_dc  (ser_dc)
    );

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            init_ff     <= 1'b0;
            rd_prev_ff  <= 1'b1;
            wr_prev_ff  <= 1'b1;
            scl_prev_ff <= 1'b0;
        end else begin
            init_ff     <= init_n_s; // RULE10
            rd_prev_ff  <= rd_s;
            wr_prev_ff  <= wr_s;
            scl_prev_ff <= scl;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wv_ff <= 1'b0;
            wb_ff <= `HP_BYTE_RST;
            wd_ff <= 1'b0;
        end else if (par_write) begin
            wv_ff <= 1'b1;
            wb_ff <= data_s; // RULE3
            wd_ff <= dc_s;   // RULE4
        end else if (ser_vld && live) begin
            wv_ff <= 1'b1;
            wb_ff <= ser_byte;
            wd_ff <= ser_dc; // RULE4
        end else begin
            wv_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rq_ff   <= 1'b0;
            rqd_ff  <= 1'b0;
            oe_ff   <= 1'b0;
            dout_ff <= `HP_BYTE_RST;
        end else begin
            rq_ff   <= read_start;
            if (read_start) begin
                rqd_ff <= dc_s; // RULE4
            end
            oe_ff   <= par_read; // RULE2
            if (par_read) begin
                dout_ff <= rd_byte; // RULE6
            end
        end
    end

    assign data_out    = dout_ff;
    assign data_oe     = {DW{oe_ff}}; // RULE2
    assign wr_vld      = wv_ff;
    assign wr_byte     = wb_ff;
    assign wr_is_data  = wd_ff;
    assign rd_req      = rq_ff;
    assign rd_is_data  = rqd_ff;
    assign init_active = !init_ff; // RULE10

    // Assertions
    bus_hiz_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE2
        !$past(selected) |-> data_oe == '0)
        else $error("bus driven while deselected");
    sel_qual_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE1
        wr_vld |-> $past(selected))
        else $error("write without select");
    split_read_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE6
        (live && parallel && !en_style && !rd_s) |=> data_oe[0])
        else $error("split read not driving");
    split_wr_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE7
        (live && parallel && !en_style && wr_s && !wr_prev_ff) |=>
        (wr_vld && wr_byte == $past(data_s)))
        else $error("split write not captured");
    en_dir_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE9
        (live && parallel && en_style && rd_s && !wr_s) |=> !data_oe[0])
        else $error("enable write drove bus");
    en_read_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE8
        (live && parallel && en_style && !rd_s) |=> !data_oe[0])
        else $error("bus driven without enable");
    dc_route_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE4
        par_write |=> wr_is_data == $past(dc_s))
        else $error("data command misrouted");
    init_hold_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE10
        !init_ff |=> !wr_vld && !data_oe[0])
        else $error("activity during init");
    ser_byte_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE14
        (parallel || !live) |=> !u_shift.vld_ff)
        else $error("serial byte outside serial mode");
    ignore_a : assert property (@(posedge clk_sys) disable iff (reset) // RULE15
        (!selected && !wr_vld) |=> !rd_req)
        else $error("read request while deselected");
endmodule : lcd_driver_host_bus_port

/* File: src/host_port_defs.svh */
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

`define HP_DATA_W       8
`define HP_SER_BITS     8
`define HP_SER_CNT_W    3
`define HP_SI_BIT       7
`define HP_SCL_BIT      6
`define HP_SER_CNT_RST  3'h0
`define HP_BYTE_RST     8'h00

`endif

/* File: src/host_port_pkg.sv */
package host_port_pkg;
    typedef enum logic {
        STYLE_SPLIT,
        STYLE_ENABLE
    } bus_style_e;

    typedef enum logic {
        LINK_SERIAL,
        LINK_PARALLEL
    } link_sel_e;
endpackage : host_port_pkg

/* File: src/pin_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser for a group of pin levels
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    // Pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync_out = sync_ff;
endmodule : pin_sync

/* File: src/serial_shifter.sv */
`timescale 1ns/10ps
`include "host_port_defs.svh"
// Shifts serial bits in MSB first, reports a full byte
module serial_shifter #(
    parameter int BITS = `HP_SER_BITS
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            reset,
    // Synchronised controls
    input  wire logic            clear,
    input  wire logic            shift_en,
    input  wire logic            bit_in,
    input  wire logic            dc_in,
    // Byte out
    output logic                 byte_vld,
    output logic [BITS-1:0]      byte_out,
    output logic                 byte_dc
);
    logic [BITS-1:0]                 sh_ff;
    logic [$clog2(BITS)-1:0]         cnt_ff;
    logic                            vld_ff;
    logic [BITS-1:0]                 out_ff;
    logic                            dc_ff;
    wire  [BITS-1:0]                 nxt_sh   = {sh_ff[BITS-2:0], bit_in};
    wire                             last_bit = (cnt_ff == ($clog2(BITS))'(BITS - 1));

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sh_ff  <= '0;
            cnt_ff <= '0;
            vld_ff <= 1'b0;
            out_ff <= '0;
            dc_ff  <= 1'b0;
        end else begin
            vld_ff <= 1'b0;
            if (clear) begin
                cnt_ff <= '0;
            end else if (shift_en) begin
                sh_ff  <= nxt_sh;
                cnt_ff <= last_bit ? '0 : cnt_ff + 1'b1;
                if (last_bit) begin
                    vld_ff <= 1'b1;
                    out_ff <= nxt_sh;
                    dc_ff  <= dc_in;
                end
            end
        end
    end

    assign byte_vld = vld_ff;
    assign byte_out = out_ff;
    assign byte_dc  = dc_ff;
endmodule : serial_shifter

/* File: test/host_model.sv */
`timescale 1ns/10ps
// Host processor: parallel strobes or write-only serial link
module host_model (
    // Clock
    input  wire logic       clk_sys,
    // Pins toward the port
    output logic            select_low_in,
    output logic            select_high_in,
    output logic            data_cmd_sel,
    output logic            rd_strobe_in,
    output logic            wr_strobe_in,
    output logic      [7:0] data_in,
    // Port drive
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe
);
    logic       drv;
    logic [7:0] val;

    // Released bus shows the inverse of the last value
    assign data_in = data_oe[0] ? data_out : (drv ? val : ~val);

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle

    task automatic park(input logic en);
        select_low_in  = 1'b1;
        select_high_in = 1'b0;
        rd_strobe_in   = ~en;
        wr_strobe_in   = 1'b1;
        drv            = 1'b0;
        val            = 8'h00;
        data_cmd_sel   = 1'($urandom);
    endtask : park

    task automatic pwrite(input logic en, input logic lo, input logic hi,
                          input logic dc, input logic [7:0] b);
        select_low_in  = lo;
        select_high_in = hi;
        data_cmd_sel   = dc;
        val            = b;
        drv            = 1'b1;
        wr_strobe_in   = 1'b0;
        if (en) rd_strobe_in = 1'b1;
        idle(4);
        if (en) rd_strobe_in = 1'b0;
        else wr_strobe_in = 1'b1;
        idle(4);
        park(en);
        idle(4);
    endtask : pwrite

    task automatic pread(input logic en, input logic lo, input logic hi, input logic dc,
                         output logic [7:0] got, output logic [7:0] oe);
        select_low_in  = lo;
        select_high_in = hi;
        data_cmd_sel   = dc;
        drv            = 1'b0;
        rd_strobe_in   = en;
        idle(6);
        got = data_out;
        oe  = data_oe;
        park(en);
        idle(4);
    endtask : pread

    task automatic swrite(input logic dc, input logic [7:0] b);
        select_low_in  = 1'b0;
        select_high_in = 1'b1;
        data_cmd_sel   = dc;
        drv            = 1'b1;
        val            = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            val[7] = b[i];
            idle(4);
            val[6] = 1'b1;
            idle(4);
            val[6] = 1'b0;
        end
        idle(4);
        park(1'b0);
        idle(4);
    endtask : swrite
endmodule : host_model

/* File: test/lcd_driver_host_bus_port_tb.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, got, exp); end end
module lcd_driver_host_bus_port_tb;
    logic       clk_sys, reset, init_in_n, bus_style_strap, link_sel_strap;
    logic       select_low_in, select_high_in, data_cmd_sel, rd_strobe_in, wr_strobe_in;
    logic       wr_vld, wr_is_data, rd_req, rd_is_data, init_active;
    logic [7:0] data_in, data_out, data_oe, wr_byte, rd_byte, got, oe;
    logic [8:0] expq[$];
    logic [31:0] r;
    logic [8:0] want;
    logic       sty, flip;
    int         failures, n_tests, cycles, n_rdreq;

    always #4 clk_sys = ~clk_sys;

    host_model host_u (.clk_sys(clk_sys), .select_low_in(select_low_in),
        .select_high_in(select_high_in), .data_cmd_sel(data_cmd_sel),
        .rd_strobe_in(rd_strobe_in), .wr_strobe_in(wr_strobe_in), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));

    lcd_driver_host_bus_port dut_u (.clk_sys(clk_sys), .reset(reset), .init_in_n(init_in_n),
        .select_low_in(select_low_in), .select_high_in(select_high_in),
        .data_cmd_sel(data_cmd_sel), .rd_strobe_in(rd_strobe_in),
        .wr_strobe_in(wr_strobe_in), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .bus_style_strap(bus_style_strap),
        .link_sel_strap(link_sel_strap), .wr_vld(wr_vld), .wr_byte(wr_byte),
        .wr_is_data(wr_is_data), .rd_req(rd_req), .rd_is_data(rd_is_data),
        .rd_byte(rd_byte), .init_active(init_active));

    task automatic complete_run;
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Every accepted byte must match the oldest note
    always @(negedge clk_sys) begin
        if (wr_vld === 1'b1) begin
            if (expq.size() == 0) begin
                `CHK(wr_vld, 1'b0)
            end else begin
                want = expq.pop_front();
                `CHK({wr_is_data, wr_byte}, want)
            end
        end
        if (rd_req === 1'b1) begin
            n_rdreq++;
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        init_in_n = 1'b1;
        bus_style_strap = 1'b0;
        link_sel_strap = 1'b1;
        rd_byte = 8'($urandom(76813));
        host_u.park(1'b0);
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        host_u.idle(4);
        flip = 1'($urandom);
        for (int en = 0; en < 2; en++) begin
            sty = en[0] ^ flip;
            bus_style_strap = sty;
            host_u.park(sty);
            host_u.idle(6);
            for (int k = 0; k < 4; k++) begin
                r = $urandom;
                expq.push_back(r[8:0]);
                host_u.pwrite(sty, 1'b0, 1'b1, r[8], r[7:0]);
            end
            host_u.pwrite(sty, 1'b1, 1'b1, 1'b1, 8'hA5);
            host_u.pwrite(sty, 1'b0, 1'b0, 1'b0, 8'h5A);
            host_u.pwrite(sty, 1'b1, 1'b0, 1'b1, 8'h3C);
            r = $urandom;
            rd_byte = r[7:0];
            host_u.pread(sty, 1'b0, 1'b1, r[8], got, oe);
            `CHK(got, r[7:0])
            `CHK(oe, 8'hFF)
            `CHK(rd_is_data, r[8])
            `CHK(n_rdreq, en + 1)
            r = $urandom;
            // Any deselected pair: never low select low with high select high
            host_u.pread(sty, r[9], r[9] & r[10], r[8], got, oe);
            `CHK(oe, 8'h00)
            `CHK(data_oe, 8'h00)
            `CHK(n_rdreq, en + 1)
        end
        link_sel_strap = 1'b0;
        host_u.park(1'b0);
        host_u.idle(6);
        for (int k = 0; k < 3; k++) begin
            r = $urandom;
            expq.push_back(r[8:0]);
            host_u.swrite(r[8], r[7:0]);
        end
        link_sel_strap = 1'b1;
        bus_style_strap = 1'b0;
        init_in_n = 1'b0;
        host_u.idle(6);
        `CHK(init_active, 1'b1)
        host_u.pwrite(1'b0, 1'b0, 1'b1, 1'b1, 8'hC3);
        init_in_n = 1'b1;
        host_u.idle(6);
        `CHK(init_active, 1'b0)
        expq.push_back(9'h0E7);
        host_u.pwrite(1'b0, 1'b0, 1'b1, 1'b0, 8'hE7);
        host_u.idle(10);
        `CHK(expq.size(), 0)
        complete_run();
    end
endmodule : lcd_driver_host_bus_port_tb
